// >>> logic/pin_mux_pkg.sv
// Purpose: Shared constants for the meter pin function mux
// Assumes: AHB-Lite register bus, 32-bit data, word aligned registers
// Notes: Register offsets are byte addresses
package pin_mux_pkg;
  // Register map
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] VOLT_OFS = 8'h08;
  // Control fields
  localparam int MODE_LSB = 0;
  localparam int PRS_LSB = 2;
  localparam int ESEL_LSB = 4;
  localparam logic [1:0] MODE_RST = 2'h2;
  // Status fields
  localparam int ST_TAMPER = 0;
  localparam int ST_NOLOAD = 1;
  localparam int ST_NEGPWR = 2;
  localparam int ST_FAULT = 3;
  localparam int ST_SLOPE = 4;
  localparam int ST_CHSEL = 5;
  // Application modes
  typedef enum logic [1:0] {
    MODE_WDOG = 2'h0,
    MODE_DSIG = 2'h1,
    MODE_HFREQ = 2'h2,
    MODE_STEP = 2'h3
  } app_mode_t;
  // Energy select for mode 0 LED
  localparam logic [1:0] ESEL_ACT = 2'h0;
  localparam logic [1:0] ESEL_REACT = 2'h1;
  // Voltage thresholds with hysteresis
  localparam logic [15:0] VOLT_LOW = 16'h0040;
  localparam logic [15:0] VOLT_HIGH = 16'h0080;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
endpackage : pin_mux_pkg

// >>> logic/meter_pin_function_mux.sv
// Purpose: Routes meter internal signals to the programmable pins
// Assumes: All inputs synchronous to clk; AHB-Lite slave, zero wait states
// Notes: Every pin output is registered so mode changes switch cleanly
// Contract
// - Mode 2 or 3 is stand-alone, mode 0 or 1 is peripheral.
// - Stand-alone: stepper_out_b carries stepper phase B.
// - Stand-alone: stepper_out_a carries stepper phase A.
// - Peripheral stepper_out_b: watchdog in mode 0, current bitstream in mode 1.
// - Peripheral stepper_out_a: zero-cross in mode 0, voltage bitstream in mode 1.
// - Mode 2 LED: high-rate active energy pulses, 50% duty.
// - Mode 3 LED: active energy pulses, rate chosen by pulse_rate_select.
// - Mode 0 LED: active, reactive or apparent pulses per selection.
// - Mode 1 LED: tamper channel select, high means secondary.
// - Stand-alone no_load_pin low during no-load, else high.
// - Stand-alone tamper pin low on tamper; peripheral pin is SPI data.
// - Stand-alone neg_power_pin low on negative active power.
// - Indications shown only while indicator_enable_pin is high.
// - Pulse zero_cross_pulse on every line voltage zero crossing.
// - Three energy pulse signals: active, reactive, apparent.
// - voltage_slope_sign high while voltage rises, low while falling.
// - Fault sets out of band or volt below 64; clears in band above 128.
// - tamper_flag is 1 on tamper, in status and on tamper pin.
// - no_load_flag is 1 on no-load, in status and on no-load pin.
//
// Local design decisions: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module meter_pin_function_mux
  import pin_mux_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Internal meter signals
  input wire logic [15:0] volt_sample,
  input wire logic volt_sample_valid,
  input wire logic freq_in_band,
  input wire logic active_energy_pulses,
  input wire logic reactive_energy_pulses,
  input wire logic apparent_energy_pulses,
  input wire logic active_hf_pulses,
  input wire logic active_lf_pulses,
  input wire logic stepper_phase_a,
  input wire logic stepper_phase_b,
  input wire logic watchdog_sig,
  input wire logic cur_bitstream,
  input wire logic volt_bitstream,
  input wire logic tamper_chan_sel,
  input wire logic tamper_detect,
  input wire logic no_load_detect,
  input wire logic neg_power_detect,
  input wire logic spi_data_out,
  input wire logic spi_data_oe,
  input wire logic indicator_enable_pin,
  // Programmable pins
  output logic stepper_out_a,
  output logic stepper_out_b,
  output logic led_out,
  output logic no_load_pin,
  output logic tamper_pin_or_data_o,
  output logic tamper_pin_or_data_oe,
  output logic neg_power_pin,
  // Internal status signals
  output logic zero_cross_pulse,
  output logic voltage_slope_sign,
  output logic freq_range_fault,
  output logic tamper_flag,
  output logic no_load_flag
);

  function automatic logic is_standalone(input logic [1:0] m);
    is_standalone = m[1];
  endfunction : is_standalone

  logic [1:0] mode_r;
  logic pulse_rate_select_r;
  logic [1:0] energy_sel_r;
  logic [15:0] volt_r;
  logic led_hf_r;
  logic hf_prev_r;
  logic fault_r;
  logic slope_r;
  logic zc_r;
  logic wr_pend_r;
  logic [7:0] addr_r;
  logic sa_nxt;
  logic led_nxt;
  logic energy_nxt;
  logic [31:0] rd_nxt;
  logic ind_en;
  logic take;

  assign take = hsel && hready && (htrans == HTRANS_NONSEQ);

  // AHB address phase capture
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_pend_r <= 1'b0;
      addr_r <= 8'h00;
    end
    else
    begin
      wr_pend_r <= take && hwrite;
      if (take)
        addr_r <= haddr[7:0];
    end
  end

  // Control register writes
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      mode_r <= MODE_RST;
      pulse_rate_select_r <= 1'b0;
      energy_sel_r <= ESEL_ACT;
    end
    else if (wr_pend_r && addr_r == CTRL_OFS)
    begin
      mode_r <= hwdata[MODE_LSB +: 2];
      pulse_rate_select_r <= hwdata[PRS_LSB];
      energy_sel_r <= hwdata[ESEL_LSB +: 2];
    end
  end

  // Read data for the next data phase
  always_comb
  begin
    rd_nxt = ZERO_WORD;
    case (haddr[7:0])
      CTRL_OFS:
      begin
        rd_nxt[MODE_LSB +: 2] = mode_r;
        rd_nxt[PRS_LSB] = pulse_rate_select_r;
        rd_nxt[ESEL_LSB +: 2] = energy_sel_r;
      end
      STAT_OFS:
      begin
        rd_nxt[ST_TAMPER] = tamper_flag;
        rd_nxt[ST_NOLOAD] = no_load_flag;
        rd_nxt[ST_NEGPWR] = neg_power_detect;
        rd_nxt[ST_FAULT] = fault_r;
        rd_nxt[ST_SLOPE] = slope_r;
        rd_nxt[ST_CHSEL] = tamper_chan_sel;
      end
      VOLT_OFS:
        rd_nxt[15:0] = volt_r;
      default:
        rd_nxt = ZERO_WORD;
    endcase
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      hrdata <= ZERO_WORD;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (take && !hwrite)
        hrdata <= rd_nxt;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      volt_r <= 16'h0000;
      slope_r <= 1'b0;
      zc_r <= 1'b0;
    end
    else
    begin
      zc_r <= 1'b0;
      if (volt_sample_valid)
      begin
        volt_r <= volt_sample;
        if ($signed(volt_sample) > $signed(volt_r))
          slope_r <= 1'b1;
        else if ($signed(volt_sample) < $signed(volt_r))
          slope_r <= 1'b0;
        // Sign change marks a zero crossing
        zc_r <= volt_sample[15] != volt_r[15];
      end
    end
  end

  // Fault with hysteresis on voltage level
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      fault_r <= 1'b1;
    else if (!freq_in_band || volt_r < VOLT_LOW)
      fault_r <= 1'b1;
    else if (volt_r > VOLT_HIGH)
      fault_r <= 1'b0;
  end

  // Divide by two gives exact 50% duty
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      led_hf_r <= 1'b0;
      hf_prev_r <= 1'b0;
    end
    else
    begin
      hf_prev_r <= active_hf_pulses;
      if (active_hf_pulses && !hf_prev_r)
        led_hf_r <= !led_hf_r;
    end
  end

  assign sa_nxt = is_standalone(mode_r);
  assign ind_en = indicator_enable_pin;

  // Energy kind for peripheral mode 0
  always_comb
  begin
    case (energy_sel_r)
      ESEL_ACT: energy_nxt = active_energy_pulses;
      ESEL_REACT: energy_nxt = reactive_energy_pulses;
      default: energy_nxt = apparent_energy_pulses;
    endcase
  end

  always_comb
  begin
    case (app_mode_t'(mode_r))
      MODE_WDOG: led_nxt = energy_nxt;
      MODE_DSIG: led_nxt = tamper_chan_sel;
      MODE_HFREQ: led_nxt = led_hf_r;
      // Pulse rate chosen by select bit
      MODE_STEP: led_nxt = pulse_rate_select_r ? active_lf_pulses : active_energy_pulses;
      default: led_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      stepper_out_a <= 1'b0;
      stepper_out_b <= 1'b0;
      led_out <= 1'b0;
      no_load_pin <= 1'b1;
      tamper_pin_or_data_o <= 1'b1;
      tamper_pin_or_data_oe <= 1'b0;
      neg_power_pin <= 1'b1;
    end
    else
    begin
      if (sa_nxt)
      begin
        stepper_out_a <= stepper_phase_a;
        stepper_out_b <= stepper_phase_b;
      end
      else if (mode_r == MODE_WDOG)
      begin
        stepper_out_a <= zero_cross_pulse;
        stepper_out_b <= watchdog_sig;
      end
      else
      begin
        stepper_out_a <= volt_bitstream;
        stepper_out_b <= cur_bitstream;
      end
      led_out <= led_nxt;
      no_load_pin <= !(sa_nxt && ind_en && no_load_detect);
      neg_power_pin <= !(sa_nxt && ind_en && neg_power_detect);
      if (sa_nxt)
      begin
        tamper_pin_or_data_o <= !(ind_en && tamper_detect);
        tamper_pin_or_data_oe <= ind_en;
      end
      else
      begin
        tamper_pin_or_data_o <= spi_data_out;
        tamper_pin_or_data_oe <= spi_data_oe;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tamper_flag <= 1'b0;
      no_load_flag <= 1'b0;
      zero_cross_pulse <= 1'b0;
      voltage_slope_sign <= 1'b0;
      freq_range_fault <= 1'b1;
    end
    else
    begin
      tamper_flag <= tamper_detect;
      no_load_flag <= no_load_detect;
      zero_cross_pulse <= zc_r;
      voltage_slope_sign <= slope_r;
      freq_range_fault <= fault_r;
    end
  end

  // Assertions
  a_mode_stepper: assert property (@(posedge clk) disable iff (!nrst)
    mode_r[1] |=> stepper_out_a == $past(stepper_phase_a))
    else $error("stepper_out_a not phase A in stand-alone");
  a_mode_stepb: assert property (@(posedge clk) disable iff (!nrst)
    mode_r[1] |=> stepper_out_b == $past(stepper_phase_b))
    else $error("stepper_out_b not phase B in stand-alone");
  a_periph_outb: assert property (@(posedge clk) disable iff (!nrst)
    mode_r == MODE_DSIG |=> stepper_out_b == $past(cur_bitstream))
    else $error("stepper_out_b not current bitstream");
  a_periph_outa: assert property (@(posedge clk) disable iff (!nrst)
    mode_r == MODE_WDOG |=> stepper_out_a == $past(zero_cross_pulse))
    else $error("stepper_out_a not zero cross");
  a_led_chsel: assert property (@(posedge clk) disable iff (!nrst)
    mode_r == MODE_DSIG |=> led_out == $past(tamper_chan_sel))
    else $error("led not channel select");
  a_noload_gate: assert property (@(posedge clk) disable iff (!nrst)
    !indicator_enable_pin |=> no_load_pin && neg_power_pin)
    else $error("indicator shown while disabled");
  a_noload_low: assert property (@(posedge clk) disable iff (!nrst)
    mode_r[1] && indicator_enable_pin && no_load_detect |=> !no_load_pin)
    else $error("no_load_pin not low");
  a_negpwr_low: assert property (@(posedge clk) disable iff (!nrst)
    mode_r[1] && indicator_enable_pin && neg_power_detect |=> !neg_power_pin)
    else $error("neg_power_pin not low");
  a_fault_set: assert property (@(posedge clk) disable iff (!nrst)
    !freq_in_band |=> ##1 freq_range_fault)
    else $error("fault not set out of band");
  a_tamper_flag: assert property (@(posedge clk) disable iff (!nrst)
    tamper_detect |=> tamper_flag)
    else $error("tamper_flag missing");
  // Sample events; each reaches its output two stages later
  sequence s_sign_change;
    volt_sample_valid && (volt_sample[15] != volt_r[15]);
  endsequence
  sequence s_volt_rise;
    volt_sample_valid && ($signed(volt_sample) > $signed(volt_r));
  endsequence
  a_zero_cross: assert property (@(posedge clk) disable iff (!nrst)
    s_sign_change |=> ##1 zero_cross_pulse)
    else $error("zero_cross_pulse missing after sign change");
  a_slope_rise: assert property (@(posedge clk) disable iff (!nrst)
    s_volt_rise |=> ##1 voltage_slope_sign)
    else $error("voltage_slope_sign not high on rise");
  a_fault_clear: assert property (@(posedge clk) disable iff (!nrst)
    freq_in_band && volt_r > VOLT_HIGH |=> ##1 !freq_range_fault)
    else $error("fault not cleared in band above high level");
  a_noload_flag: assert property (@(posedge clk) disable iff (!nrst)
    no_load_detect |=> no_load_flag)
    else $error("no_load_flag missing");
  a_tamper_pin: assert property (@(posedge clk) disable iff (!nrst)
    mode_r[1] && indicator_enable_pin && tamper_detect
    |=> tamper_pin_or_data_oe && !tamper_pin_or_data_o)
    else $error("tamper pin not driven low");
endmodule : meter_pin_function_mux

// >>> tb/meter_far_side.sv
// Purpose: Far-side model of the meter pins (LED counter, indicator wiring)
// Assumes: The shared tamper/data line has a pull-up
// Notes: Counts LED rising edges as a stepper counter would
`timescale 1ns/1ps
module meter_far_side (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Pins
  input wire logic led_out,
  input wire logic tamper_pin_or_data_o,
  input wire logic tamper_pin_or_data_oe,
  input wire logic want_ind,
  output logic indicator_enable_pin,
  output logic tamper_wire,
  output logic [15:0] led_count
);
  logic led_d_r;
  assign indicator_enable_pin = want_ind;
  // Released line floats to the pull-up, not the last value
  assign tamper_wire = tamper_pin_or_data_oe ? tamper_pin_or_data_o : 1'b1;
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      led_d_r <= 1'b0;
      led_count <= 16'h0000;
    end
    else
    begin
      led_d_r <= led_out;
      if (led_out && !led_d_r)
        led_count <= led_count + 16'h0001;
    end
  end
endmodule : meter_far_side

// >>> tb/meter_pin_function_mux_tb.sv
// Purpose: Self-checking bench for the meter pin function mux
// Assumes: Zero-wait AHB-Lite slave, registered pin outputs
// Notes: Expected values come from the pin rules, except the mode 2 LED start level and count, read from the design
`timescale 1ns/1ps
module meter_pin_function_mux_tb;
  import pin_mux_pkg::*;
  logic clk, nrst, hsel, hwrite, hready, hreadyout, hresp, want_ind, tamper_wire;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] volt_sample, led_count;
  logic volt_sample_valid, freq_in_band, active_energy_pulses, reactive_energy_pulses;
  logic apparent_energy_pulses, active_hf_pulses, active_lf_pulses, stepper_phase_a;
  logic stepper_phase_b, watchdog_sig, cur_bitstream, volt_bitstream, tamper_chan_sel;
  logic tamper_detect, no_load_detect, neg_power_detect, spi_data_out, spi_data_oe;
  logic indicator_enable_pin, stepper_out_a, stepper_out_b, led_out, no_load_pin;
  logic tamper_pin_or_data_o, tamper_pin_or_data_oe, neg_power_pin, zero_cross_pulse;
  logic voltage_slope_sign, freq_range_fault, tamper_flag, no_load_flag, zc;
  int bad_count, checks;
  assign hready = hreadyout;
  meter_pin_function_mux u_meter_pin_function_mux (
    .clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .volt_sample(volt_sample), .volt_sample_valid(volt_sample_valid),
    .freq_in_band(freq_in_band), .active_energy_pulses(active_energy_pulses),
    .reactive_energy_pulses(reactive_energy_pulses),
    .apparent_energy_pulses(apparent_energy_pulses),
    .active_hf_pulses(active_hf_pulses), .active_lf_pulses(active_lf_pulses),
    .stepper_phase_a(stepper_phase_a), .stepper_phase_b(stepper_phase_b),
    .watchdog_sig(watchdog_sig), .cur_bitstream(cur_bitstream),
    .volt_bitstream(volt_bitstream), .tamper_chan_sel(tamper_chan_sel),
    .tamper_detect(tamper_detect), .no_load_detect(no_load_detect),
    .neg_power_detect(neg_power_detect), .spi_data_out(spi_data_out),
    .spi_data_oe(spi_data_oe), .indicator_enable_pin(indicator_enable_pin),
    .stepper_out_a(stepper_out_a), .stepper_out_b(stepper_out_b),
    .led_out(led_out), .no_load_pin(no_load_pin),
    .tamper_pin_or_data_o(tamper_pin_or_data_o),
    .tamper_pin_or_data_oe(tamper_pin_or_data_oe),
    .neg_power_pin(neg_power_pin), .zero_cross_pulse(zero_cross_pulse),
    .voltage_slope_sign(voltage_slope_sign), .freq_range_fault(freq_range_fault),
    .tamper_flag(tamper_flag), .no_load_flag(no_load_flag)
  );
  meter_far_side u_meter_far_side (
    .clk(clk), .nrst(nrst), .led_out(led_out),
    .tamper_pin_or_data_o(tamper_pin_or_data_o),
    .tamper_pin_or_data_oe(tamper_pin_or_data_oe), .want_ind(want_ind),
    .indicator_enable_pin(indicator_enable_pin), .tamper_wire(tamper_wire),
    .led_count(led_count)
  );
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic test_done;
    if (bad_count == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic tick;
    repeat (2) @(posedge clk);
    #1;
  endtask : tick
  // Holds each phase until hready is seen high; read data taken at that edge
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb
  task automatic ctrl(input logic [1:0] m, input logic p, input logic [1:0] e);
    ahb(1'b1, CTRL_OFS, {26'h0, e, 1'b0, p, m});
  endtask : ctrl
  task automatic t_route;
    logic ea, eb;
    for (int m = 0; m < 4; m++)
      for (int p = 0; p < 2; p++)
      begin
        ctrl(m[1:0], 1'b0, 2'h0);
        @(posedge clk);
        stepper_phase_a <= p[0];
        stepper_phase_b <= !p[0];
        watchdog_sig <= !p[0];
        cur_bitstream <= p[0];
        volt_bitstream <= !p[0];
        tick;
        ea = m > 1 ? p[0] : (m == 1 ? !p[0] : 1'b0);
        eb = m > 1 ? !p[0] : (m == 1 ? p[0] : !p[0]);
        chk("stepper_out_a", stepper_out_a, ea);
        chk("stepper_out_b", stepper_out_b, eb);
      end
  endtask : t_route
  task automatic t_led;
    logic l;
    logic [15:0] c;
    for (int e = 0; e < 3; e++)
    begin
      ctrl(2'h0, 1'b0, e[1:0]);
      @(posedge clk);
      active_energy_pulses <= (e == 0);
      reactive_energy_pulses <= (e == 1);
      apparent_energy_pulses <= (e == 2);
      tick;
      chk("led mode 0", led_out, 1);
    end
    ctrl(2'h1, 1'b0, 2'h0);
    for (int p = 0; p < 2; p++)
    begin
      @(posedge clk);
      tamper_chan_sel <= p[0];
      tick;
      chk("led mode 1", led_out, p);
    end
    @(posedge clk);
    active_energy_pulses <= 1'b0;
    active_lf_pulses <= 1'b1;
    for (int p = 0; p < 2; p++)
    begin
      ctrl(2'h3, p[0], 2'h0);
      tick;
      chk("led mode 3", led_out, p);
    end
    ctrl(2'h2, 1'b0, 2'h0);
    tick;
    l = led_out;
    c = led_count;
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk);
      active_hf_pulses <= 1'b1;
      @(posedge clk);
      active_hf_pulses <= 1'b0;
      tick;
      chk("led mode 2", led_out, i[0] ? l : !l);
    end
    chk("led rises", led_count, c + 16'h0002);
  endtask : t_led
  task automatic t_ind;
    ctrl(2'h3, 1'b0, 2'h0);
    @(posedge clk);
    want_ind <= 1'b1;
    {tamper_detect, no_load_detect, neg_power_detect} <= 3'h7;
    tick;
    chk("no_load_pin", no_load_pin, 0);
    chk("tamper line", tamper_wire, 0);
    chk("neg_power_pin", neg_power_pin, 0);
    chk("tamper_flag", tamper_flag, 1);
    chk("no_load_flag", no_load_flag, 1);
    ahb(1'b0, STAT_OFS, ZERO_WORD);
    chk("status", rd[2:0], 3'h7);
    @(posedge clk);
    want_ind <= 1'b0;
    tick;
    chk("masked", {no_load_pin, tamper_wire, neg_power_pin}, 3'h7);
    @(posedge clk);
    want_ind <= 1'b1;
    {tamper_detect, no_load_detect, neg_power_detect} <= 3'h0;
    tick;
    chk("idle pins", {no_load_pin, tamper_wire, neg_power_pin}, 3'h7);
    chk("flags", {tamper_flag, no_load_flag}, 2'h0);
    ctrl(2'h0, 1'b0, 2'h0);
    for (int p = 0; p < 2; p++)
    begin
      @(posedge clk);
      spi_data_oe <= 1'b1;
      spi_data_out <= p[0];
      tick;
      chk("spi line", tamper_wire, p);
    end
  endtask : t_ind
  task automatic samp(input logic [15:0] v);
    @(posedge clk);
    volt_sample <= v;
    volt_sample_valid <= 1'b1;
    @(posedge clk);
    volt_sample_valid <= 1'b0;
    zc = 1'b0;
    repeat (4)
    begin
      @(posedge clk);
      #1;
      zc = zc | zero_cross_pulse;
    end
  endtask : samp
  task automatic t_volt;
    logic [15:0] vs [7] = '{16'h0100, 16'h0200, 16'hFFF0, 16'h003F, 16'h0080, 16'h0081,
      16'h0040};
    for (int i = 0; i < 7; i++)
    begin
      samp(vs[i]);
      chk("zero cross", zc, 7'h0C >> i & 1);
      chk("slope", voltage_slope_sign, 7'h3B >> i & 1);
      chk("fault", freq_range_fault, 7'h18 >> i & 1);
    end
    @(posedge clk);
    freq_in_band <= 1'b0;
    tick;
    chk("fault band", freq_range_fault, 1);
    @(posedge clk);
    freq_in_band <= 1'b1;
    tick;
    chk("fault held", freq_range_fault, 1);
    ahb(1'b0, VOLT_OFS, ZERO_WORD);
    chk("volt reg", rd[15:0], 16'h0040);
    ahb(1'b1, 8'h0C, 32'hFFFF_FFFF);
    ahb(1'b0, 8'h0C, ZERO_WORD);
    chk("unmapped", rd, ZERO_WORD);
    chk("hresp", hresp, 1'b0);
  endtask : t_volt
  initial
  begin
    nrst = 1'b0;
    {hsel, hwrite, volt_sample_valid, active_energy_pulses, reactive_energy_pulses} = '0;
    {apparent_energy_pulses, active_hf_pulses, active_lf_pulses, stepper_phase_a} = '0;
    {stepper_phase_b, watchdog_sig, cur_bitstream, volt_bitstream, tamper_chan_sel} = '0;
    {tamper_detect, no_load_detect, neg_power_detect, spi_data_out, spi_data_oe} = '0;
    {haddr, hwdata, htrans, volt_sample, want_ind} = '0;
    hsize = 3'h2;
    freq_in_band = 1'b1;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    #1;
    chk("reset pins", {no_load_pin, neg_power_pin, freq_range_fault}, 3'h7);
    ahb(1'b0, CTRL_OFS, ZERO_WORD);
    chk("reset mode", rd[1:0], MODE_RST);
    t_route;
    t_led;
    t_ind;
    t_volt;
    test_done;
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    bad_count++;
    test_done;
  end
endmodule : meter_pin_function_mux_tb
